// file: design/chop_detect_pkg.sv
package chop_detect_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map and field layout.
   localparam int         ADDR_W       = 4;
   localparam int         REG_W        = 16;
   localparam logic [3:0] SPARE_OFS    = 4'h5;
   localparam logic [3:0] CFG_OFS      = 4'h6;
   localparam logic [3:0] TH_UP_OFS    = 4'h7;
   localparam logic [3:0] TH_LO_OFS    = 4'h8;
   localparam logic [3:0] IRQ_STAT_OFS = 4'hC;
   localparam logic [3:0] IRQ_EN_OFS   = 4'hD;
   localparam logic [3:0] IRQ_CLR_OFS  = 4'hE;

   localparam logic [15:0] CFG_RST     = 16'h0600;
   localparam logic [15:0] CFG_MASK    = 16'h1FFF;
   localparam logic [15:0] TH_RST      = 16'h0000;
   localparam logic [15:0] TH_LO_MASK  = 16'hFF00;
   localparam int          DLY_MSB     = 12;
   localparam int          DLY_LSB     = 9;
   localparam int          CHOP_EN_BIT = 8;
   localparam int          ALLCH_BIT   = 7;
   localparam int          NUM_MSB     = 6;
   localparam int          NUM_LSB     = 4;
   localparam int          LEN_MSB     = 3;
   localparam int          LEN_LSB     = 1;
   localparam int          DET_EN_BIT  = 0;
   localparam int          TH_LO_MSB   = 15;
   localparam int          TH_LO_LSB   = 8;

   // Interrupt status bits.
   localparam int         IRQ_W        = 3;
   localparam int         IRQ_DETECT   = 0;
   localparam int         IRQ_MEAS     = 1;
   localparam int         IRQ_SETTLED  = 2;
   localparam logic [2:0] IRQ_RST      = 3'h0;

   // Counter widths: settling in modulator periods, window in conversion periods, exceedances.
   localparam int SETTLE_W = 17;
   localparam int LEN_W    = 12;
   localparam int EXC_W    = 8;

   typedef enum logic [1:0] {
      CD_IDLE = 2'b01,
      CD_MEAS = 2'b10
   } detect_state_t;

   // Settling delay of 2^(code+1) modulator periods.
   function automatic logic [SETTLE_W-1:0] settle_len(input logic [3:0] code);
      settle_len = SETTLE_W'(17'h00002 << code);
   endfunction : settle_len

   // Measurement length in conversion periods.
   function automatic logic [LEN_W-1:0] meas_len(input logic [2:0] code);
      case (code)
         3'h0:    meas_len = 12'h080;
         3'h1:    meas_len = 12'h100;
         3'h2:    meas_len = 12'h200;
         3'h3:    meas_len = 12'h300;
         3'h4:    meas_len = 12'h500;
         3'h5:    meas_len = 12'h700;
         3'h6:    meas_len = 12'hA00;
         default: meas_len = 12'hE00;
      endcase
   endfunction : meas_len

   // Exceedances needed for a detection, 2^code.
   function automatic logic [EXC_W:0] exc_target(input logic [2:0] code);
      exc_target = (EXC_W+1)'(9'h001 << code);
   endfunction : exc_target

endpackage : chop_detect_pkg

// file: design/chop_settle_timer.sv
module chop_settle_timer
   import chop_detect_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       reset_i,
   input  wire logic       ce_i,
   input  wire logic       start_i,
   input  wire logic       mod_tick_i,
   input  wire logic [3:0] dly_code_i,
   output logic            settling_o,
   output logic            done_o
);

   logic [SETTLE_W-1:0] cnt_r;
   logic [SETTLE_W-1:0] cnt_nxt;
   logic                done_r;
   wire                 last_w = mod_tick_i && (cnt_r == SETTLE_W'(1));

   ////////////////////////////////////////////////////////////////////////////
   // A start loads the delay; each modulator tick counts one period down.
   always_comb begin
      cnt_nxt = cnt_r;
      if (start_i) begin
         cnt_nxt = settle_len(dly_code_i);
      end else if (mod_tick_i && cnt_r != '0) begin
         cnt_nxt = cnt_r - SETTLE_W'(1);
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else if (ce_i) begin
         cnt_r  <= cnt_nxt;
         done_r <= last_w && !start_i;
      end
   end

   assign settling_o = (cnt_r != '0);
   assign done_o     = done_r && ce_i;

   ////////////////////////////////////////////////////////////////////////////
   // Helper: ticks seen since the last start, and the delay then chosen.
   logic [SETTLE_W:0]   seen_r;
   logic [SETTLE_W-1:0] want_r;
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         seen_r <= '0;
         want_r <= '0;
      end else if (ce_i) begin
         if (start_i) begin
            seen_r <= '0;
            want_r <= settle_len(dly_code_i);
         end else if (mod_tick_i && settling_o) begin
            seen_r <= seen_r + (SETTLE_W+1)'(1);
         end
      end
   end

   AST_SETTLE_LEN: assert property (@(posedge mclk_i) disable iff (reset_i)
      done_o |-> seen_r == {1'b0, want_r})
      else $error("Settling ended after the wrong number of periods.");

   AST_SETTLE_START: assert property (@(posedge mclk_i) disable iff (reset_i)
      ce_i && start_i |=> settling_o)
      else $error("Settling did not begin on start.");

endmodule : chop_settle_timer

// file: design/chop_detect_config.sv
// Operation
// - Chop waits 2^(code+1) modulator periods before measuring; default 16.
// - Global chop runs only while chop enable bit 8 is one; reset zero.
// - Bit 7 zero: any channel exceeding triggers; one: all channels must.
// - Detection signalled once exceedance count reaches 2^code, code in bits 6:4.
// - Measurement spans 128 to 3584 conversion periods, code in bits 3:1.
// - Configuration word resets to 0600h, delay code 0011b in bits 12:9.
// - Threshold is 24 bits: upper word plus bits 15:8 of next word.
module chop_detect_config
   import chop_detect_pkg::*;
#(
   parameter int CH_NUM = 2,
   parameter int DATA_W = 24
)(
   input  wire logic                     mclk_i,
   input  wire logic                     reset_i,
   input  wire logic                     ce_i,
   input  wire logic [ADDR_W-1:0]        addr_i,
   input  wire logic [REG_W-1:0]         wdata_i,
   input  wire logic                     wr_i,
   input  wire logic                     rd_i,
   output logic      [REG_W-1:0]         rdata_o,
   input  wire logic                     mod_tick_i,
   input  wire logic                     conv_tick_i,
   input  wire logic                     chop_start_i,
   input  wire logic [CH_NUM*DATA_W-1:0] ch_data_i,
   output logic                          chop_active_o,
   output logic                          measure_ok_o,
   output logic                          detect_o,
   output logic                          irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.
   if (CH_NUM < 1 || DATA_W != 24) begin : g_bad_param
      $error("Unsupported channel count or sample width.");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register decode.
   wire wr_cfg_w   = ce_i && wr_i && (addr_i == CFG_OFS);
   wire wr_thu_w   = ce_i && wr_i && (addr_i == TH_UP_OFS);
   wire wr_thl_w   = ce_i && wr_i && (addr_i == TH_LO_OFS);
   wire wr_en_w    = ce_i && wr_i && (addr_i == IRQ_EN_OFS);
   wire wr_clr_w   = ce_i && wr_i && (addr_i == IRQ_CLR_OFS);

   logic [REG_W-1:0] cfg_r;
   logic [REG_W-1:0] th_up_r;
   logic [REG_W-1:0] th_lo_r;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_en_r;
   logic [REG_W-1:0] rdata_r;
   logic [REG_W-1:0] rd_mux_w;

   // Fields of the configuration word.
   wire       chop_enable                  = cfg_r[CHOP_EN_BIT];
   wire [3:0] chop_settle_delay            = cfg_r[DLY_MSB:DLY_LSB];
   wire       detect_all_channels_required = cfg_r[ALLCH_BIT];
   wire [2:0] detect_exceed_count          = cfg_r[NUM_MSB:NUM_LSB];
   wire [2:0] detect_measure_length        = cfg_r[LEN_MSB:LEN_LSB];
   wire       detect_mode_enable           = cfg_r[DET_EN_BIT];

   // Reserved bits are not stored, so they always read as zero.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg_r   <= CFG_RST;
         th_up_r <= TH_RST;
         th_lo_r <= TH_RST;
      end else begin
         if (wr_cfg_w) cfg_r <= wdata_i & CFG_MASK;
         if (wr_thu_w) th_up_r <= wdata_i;
         if (wr_thl_w) th_lo_r <= wdata_i & TH_LO_MASK;
      end
   end

   // Read selection; the spare word and unmapped offsets read zero.
   assign rd_mux_w =
      (addr_i == CFG_OFS)      ? cfg_r :
      (addr_i == TH_UP_OFS)    ? th_up_r :
      (addr_i == TH_LO_OFS)    ? th_lo_r :
      (addr_i == IRQ_STAT_OFS) ? REG_W'(irq_stat_r) :
      (addr_i == IRQ_EN_OFS)   ? REG_W'(irq_en_r) : '0;

   // Read data stand for the one cycle after the strobe.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_r <= '0;
      end else if (ce_i) begin
         rdata_r <= rd_i ? rd_mux_w : '0;
      end
   end
   assign rdata_o = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Global chop settling.
   logic settling_w;
   logic settled_w;
   chop_settle_timer u_settle (
      .mclk_i     (mclk_i),
      .reset_i    (reset_i),
      .ce_i       (ce_i),
      .start_i    (chop_start_i && chop_enable),
      .mod_tick_i (mod_tick_i),
      .dly_code_i (chop_settle_delay),
      .settling_o (settling_w),
      .done_o     (settled_w)
   );

   // Measurement is held off only while chop runs and settles.
   assign chop_active_o = chop_enable;
   assign measure_ok_o  = !(chop_enable && settling_w);

   ////////////////////////////////////////////////////////////////////////////
   // Threshold compare per channel.
   wire [DATA_W-1:0] threshold_w = {th_up_r, th_lo_r[TH_LO_MSB:TH_LO_LSB]};
   logic [CH_NUM-1:0] exceed_w;

   for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
      wire [DATA_W-1:0] smp_w = ch_data_i[c*DATA_W +: DATA_W];
      wire [DATA_W-1:0] mag_w = smp_w[DATA_W-1] ? DATA_W'(-smp_w) : smp_w;
      assign exceed_w[c] = (mag_w > threshold_w);
   end

   // Trigger condition: any channel or every channel.
   wire hit_w = detect_all_channels_required ? (&exceed_w) : (|exceed_w);
   wire sample_w = ce_i && conv_tick_i && measure_ok_o;

   ////////////////////////////////////////////////////////////////////////////
   // Current-detect sequencer.
   detect_state_t    state_r;
   detect_state_t    state_nxt;
   logic [LEN_W-1:0] conv_r;
   logic [LEN_W-1:0] conv_nxt;
   logic [EXC_W:0]   exc_r;
   logic [EXC_W:0]   exc_nxt;
   logic             fired_r;
   logic             fired_nxt;
   logic             detect_nxt;
   logic             meas_done_w;

   wire [EXC_W:0]   target_w = exc_target(detect_exceed_count);
   wire [LEN_W-1:0] len_w    = meas_len(detect_measure_length);

   always_comb begin
      state_nxt   = state_r;
      conv_nxt    = conv_r;
      exc_nxt     = exc_r;
      fired_nxt   = fired_r;
      detect_nxt  = 1'b0;
      meas_done_w = 1'b0;
      case (state_r)
         CD_IDLE: begin
            conv_nxt  = '0;
            exc_nxt   = '0;
            fired_nxt = 1'b0;
            if (detect_mode_enable) state_nxt = CD_MEAS;
         end
         CD_MEAS: begin
            if (!detect_mode_enable) begin
               state_nxt = CD_IDLE;
            end else if (sample_w) begin
               if (hit_w && exc_r != target_w) exc_nxt = exc_r + (EXC_W+1)'(1);
               if (hit_w && !fired_r && exc_r + (EXC_W+1)'(1) == target_w) begin
                  detect_nxt = 1'b1;
                  fired_nxt  = 1'b1;
               end
               if (conv_r == len_w - LEN_W'(1)) begin
                  meas_done_w = 1'b1;
                  conv_nxt    = '0;
                  exc_nxt     = '0;
                  fired_nxt   = 1'b0;
               end else begin
                  conv_nxt = conv_r + LEN_W'(1);
               end
            end
         end
         default: state_nxt = CD_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state_r  <= CD_IDLE;
         conv_r   <= '0;
         exc_r    <= '0;
         fired_r  <= 1'b0;
         detect_o <= 1'b0;
      end else if (ce_i) begin
         state_r  <= state_nxt;
         conv_r   <= conv_nxt;
         exc_r    <= exc_nxt;
         fired_r  <= fired_nxt;
         detect_o <= detect_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helper: samples and hits counted since the window opened. They are kept
   // apart from the sequencer so that the checks below do not lean on its counters.
   logic [LEN_W:0] win_seen_r;
   logic [LEN_W:0] hit_seen_r;
   wire            win_step_w = (state_r == CD_MEAS) && detect_mode_enable && sample_w;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         win_seen_r <= '0;
         hit_seen_r <= '0;
      end else if (ce_i) begin
         if (state_r != CD_MEAS || meas_done_w) begin
            win_seen_r <= '0;
            hit_seen_r <= '0;
         end else if (win_step_w) begin
            win_seen_r <= win_seen_r + (LEN_W+1)'(1);
            if (hit_w) hit_seen_r <= hit_seen_r + (LEN_W+1)'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky status, set wins over a clear in the same cycle.
   wire [IRQ_W-1:0] irq_set_w = {settled_w, meas_done_w, ce_i && detect_nxt};
   wire [IRQ_W-1:0] irq_clr_w = wr_clr_w ? wdata_i[IRQ_W-1:0] : '0;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_stat_r <= IRQ_RST;
         irq_en_r   <= IRQ_RST;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr_w) | irq_set_w;
         if (wr_en_w) irq_en_r <= wdata_i[IRQ_W-1:0];
      end
   end
   assign irq_o = |(irq_stat_r & irq_en_r);

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_cfg_write;
      wr_i && ce_i && addr_i == CFG_OFS;
   endsequence

   sequence s_cfg_read;
      rd_i && ce_i && addr_i == CFG_OFS;
   endsequence

   AST_CFG_READBACK: assert property (@(posedge mclk_i) disable iff (reset_i)
      s_cfg_write ##1 s_cfg_read |=> rdata_o == ($past(wdata_i, 2) & CFG_MASK))
      else $error("Configuration word read back wrong.");

   AST_CHOP_OFF_OK: assert property (@(posedge mclk_i) disable iff (reset_i)
      !chop_enable |-> measure_ok_o && !chop_active_o)
      else $error("Measurement held off with chop disabled.");

   AST_ALL_CHANNELS: assert property (@(posedge mclk_i) disable iff (reset_i)
      detect_all_channels_required && hit_w |-> &exceed_w)
      else $error("All-channel trigger fired on a partial exceedance.");

   AST_ANY_CHANNEL: assert property (@(posedge mclk_i) disable iff (reset_i)
      !detect_all_channels_required && |exceed_w |-> hit_w)
      else $error("Any-channel trigger missed an exceedance.");

   AST_DETECT_COUNT: assert property (@(posedge mclk_i) disable iff (reset_i)
      ce_i && detect_nxt && !meas_done_w |=> exc_r == $past(target_w))
      else $error("Detection at the wrong exceedance count.");

   AST_DETECT_OFF: assert property (@(posedge mclk_i) disable iff (reset_i)
      ce_i && !detect_mode_enable |=> !detect_o)
      else $error("Detection while the mode is disabled.");

   AST_MEAS_LEN: assert property (@(posedge mclk_i) disable iff (reset_i)
      meas_done_w |-> win_seen_r == {1'b0, len_w} - (LEN_W+1)'(1))
      else $error("Measurement window of wrong length.");

   AST_SETTLE_GATE: assert property (@(posedge mclk_i) disable iff (reset_i)
      chop_enable && settling_w |-> !sample_w)
      else $error("Conversion sampled while chop settles.");

   AST_STICKY: assert property (@(posedge mclk_i) disable iff (reset_i)
      irq_stat_r[IRQ_DETECT] && !(wr_clr_w && wdata_i[IRQ_DETECT]) |=> irq_stat_r[IRQ_DETECT])
      else $error("Detect status lost without a clear.");

   AST_DETECT_HITS: assert property (@(posedge mclk_i) disable iff (reset_i)
      ce_i && detect_nxt |-> hit_seen_r + (LEN_W+1)'(1) == (LEN_W+1)'(target_w))
      else $error("Detection before the selected number of exceedances.");

   AST_DETECT_MISS: assert property (@(posedge mclk_i) disable iff (reset_i)
      win_step_w && hit_w && hit_seen_r + (LEN_W+1)'(1) == (LEN_W+1)'(target_w) |-> detect_nxt)
      else $error("Detection missed at the selected exceedance count.");

   AST_START_REFUSED: assert property (@(posedge mclk_i) disable iff (reset_i)
      ce_i && chop_start_i && !chop_enable && !settling_w |=> !settling_w)
      else $error("Settling started with chop disabled.");

   AST_SETTLED_STATUS: assert property (@(posedge mclk_i) disable iff (reset_i)
      settled_w |=> irq_stat_r[IRQ_SETTLED])
      else $error("Settling done not recorded in status.");

   AST_SPARE_READ: assert property (@(posedge mclk_i) disable iff (reset_i)
      ce_i && rd_i && addr_i == SPARE_OFS |=> rdata_o == '0)
      else $error("Spare word read nonzero.");

   AST_CFG_RESERVED: assert property (@(posedge mclk_i) disable iff (reset_i)
      s_cfg_read |=> rdata_o[REG_W-1:DLY_MSB+1] == '0)
      else $error("Reserved configuration bits read nonzero.");

   AST_RDATA_STANDS: assert property (@(posedge mclk_i) disable iff (reset_i)
      ce_i && !rd_i |=> rdata_o == '0)
      else $error("Read data stood beyond one cycle.");

endmodule : chop_detect_config

// file: verification/tb_chop_detect_config.sv
module tb_chop_detect_config
   import chop_detect_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              mclk_i;
   logic              reset_i;
   logic              ce_i;
   logic [3:0]        addr_i;
   logic [15:0]       wdata_i;
   logic              wr_i;
   logic              rd_i;
   logic [15:0]       rdata_o;
   logic              mod_tick_i;
   logic              conv_tick_i;
   logic              chop_start_i;
   logic [47:0]       ch_data_i;
   logic              chop_active_o;
   logic              measure_ok_o;
   logic              detect_o;
   logic              irq_o;
   int                fails;
   int                tests_run;

   // Window lengths in conversion periods, one per length code.
   localparam int LEN_TAB [8] = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};

   chop_detect_config i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mod_tick_i(mod_tick_i),
      .conv_tick_i(conv_tick_i), .chop_start_i(chop_start_i), .ch_data_i(ch_data_i),
      .chop_active_o(chop_active_o), .measure_ok_o(measure_ok_o), .detect_o(detect_o), .irq_o(irq_o));

   ////////////////////////////////////////////////////////////////////////////
   // Clock generation and the watchdog that stops a hung run.
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   initial begin
      repeat (100000) @(posedge mclk_i);
      fails++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared comparison, bus cycles and conversion samples.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         fails++;
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask : wr

   task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1 chk(what, exp, rdata_o);
   endtask : rd_chk

   // Write followed at once by a read, strobes back to back.
   task automatic wr_rd(input string what, input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp);
      @(posedge mclk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
      rd_i    <= 1'b1;
      @(posedge mclk_i);
      rd_i    <= 1'b0;
      #1 chk(what, exp, rdata_o);
   endtask : wr_rd

   task automatic conv(input logic [23:0] s0, input logic [23:0] s1, output logic det);
      @(posedge mclk_i);
      conv_tick_i <= 1'b1;
      ch_data_i   <= {s1, s0};
      @(posedge mclk_i);
      conv_tick_i <= 1'b0;
      #1 det = detect_o;
   endtask : conv

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_reset();
      chk("chop_active", 16'h0000, 16'(chop_active_o));
      chk("irq", 16'h0000, 16'(irq_o));
      rd_chk("cfg reset", CFG_OFS, 16'h0600);
      rd_chk("spare reset", SPARE_OFS, 16'h0000);
      rd_chk("thr lower reset", TH_LO_OFS, 16'h0000);
   endtask : t_reset

   task automatic t_regs();
      wr_rd("cfg masked", CFG_OFS, 16'hFFFF, 16'h1FFF);
      chk("chop_active on", 16'h0001, 16'(chop_active_o));
      @(posedge mclk_i);
      ce_i <= 1'b0;
      wr(CFG_OFS, 16'h0000);
      ce_i <= 1'b1;
      rd_chk("cfg frozen", CFG_OFS, 16'h1FFF);
      wr(CFG_OFS, 16'h0000);
      rd_chk("cfg cleared", CFG_OFS, 16'h0000);
      wr(SPARE_OFS, 16'hFFFF);
      rd_chk("spare", SPARE_OFS, 16'h0000);
      wr(4'hF, 16'hFFFF);
      rd_chk("unmapped", 4'hF, 16'h0000);
      wr(TH_LO_OFS, 16'hFFFF);
      rd_chk("thr lower", TH_LO_OFS, 16'hFF00);
      wr(TH_UP_OFS, 16'hFFFF);
      rd_chk("thr upper", TH_UP_OFS, 16'hFFFF);
      wr(IRQ_EN_OFS, 16'h0007);
      rd_chk("irq enable", IRQ_EN_OFS, 16'h0007);
      rd_chk("irq clear reads", IRQ_CLR_OFS, 16'h0000);
      wr(IRQ_EN_OFS, 16'h0000);
   endtask : t_regs

   // Settling takes 2^(code+1) modulator ticks before measuring may resume.
   task automatic t_chop(input logic [3:0] code, input logic en);
      int n;
      n = 2 << code;
      wr(CFG_OFS, {3'h0, code, en, 8'h00});
      @(posedge mclk_i);
      chop_start_i <= 1'b1;
      @(posedge mclk_i);
      chop_start_i <= 1'b0;
      mod_tick_i   <= 1'b1;
      #1 chk("ok after start", 16'(!en), 16'(measure_ok_o));
      repeat (n - 1) @(posedge mclk_i);
      #1 chk("ok before last tick", 16'(!en), 16'(measure_ok_o));
      @(posedge mclk_i);
      mod_tick_i <= 1'b0;
      #1 chk("ok after last tick", 16'h0001, 16'(measure_ok_o));
      if (en) begin
         rd_chk("settled status", IRQ_STAT_OFS, 16'h0004);
         wr(IRQ_CLR_OFS, 16'h0007);
      end
   endtask : t_chop

   // Detection after 2^code exceedances; threshold is 000180h, any or all channels.
   task automatic t_detect(input logic [2:0] code, input logic allch);
      logic det;
      int   n;
      n = 1 << code;
      wr(CFG_OFS, 16'h0000);
      wr(IRQ_CLR_OFS, 16'h0007);
      wr(IRQ_EN_OFS, 16'h0001);
      wr(CFG_OFS, {8'h00, allch, code, 3'h1, 1'b1});
      conv(24'h000180, 24'h000180, det);
      chk("detect at equal", 16'h0000, 16'(det));
      for (int i = 0; i < n; i++) begin
         if (allch) begin
            conv(24'h000181, 24'h000000, det);
            chk("detect one of all", 16'h0000, 16'(det));
         end
         conv(i[0] ? 24'hFFFE7F : 24'h000181, allch ? 24'hFFFE7F : 24'h000180, det);
         chk("detect pulse", 16'(i == n - 1), 16'(det));
      end
      conv(24'h000181, 24'h000181, det);
      chk("detect repeat", 16'h0000, 16'(det));
      chk("irq on detect", 16'h0001, 16'(irq_o));
      wr(IRQ_EN_OFS, 16'h0002);
      #1 chk("irq masked", 16'h0000, 16'(irq_o));
      rd_chk("detect status", IRQ_STAT_OFS, 16'h0001);
      wr(IRQ_CLR_OFS, 16'h0001);
      rd_chk("status cleared", IRQ_STAT_OFS, 16'h0000);
   endtask : t_detect

   // The window-done event follows exactly the chosen number of conversions.
   task automatic t_window(input logic [2:0] lc);
      logic det;
      wr(CFG_OFS, 16'h0000);
      wr(IRQ_CLR_OFS, 16'h0007);
      wr(IRQ_EN_OFS, 16'h0002);
      wr(CFG_OFS, {12'h000, lc, 1'b1});
      repeat (LEN_TAB[lc] - 1) conv(24'h000000, 24'h000000, det);
      chk("window early", 16'h0000, 16'(irq_o));
      conv(24'h000000, 24'h000000, det);
      repeat (2) @(posedge mclk_i);
      #1 chk("window done", 16'h0001, 16'(irq_o));
   endtask : t_window

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run.
   task automatic summarize();
      if (fails == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize

   // Main sequence: reset for 16 cycles, then each scenario in turn.
   initial begin
      fails        = 0;
      tests_run    = 0;
      reset_i      = 1'b1;
      ce_i         = 1'b1;
      addr_i       = 4'h0;
      wdata_i      = 16'h0000;
      wr_i         = 1'b0;
      rd_i         = 1'b0;
      mod_tick_i   = 1'b0;
      conv_tick_i  = 1'b0;
      chop_start_i = 1'b0;
      ch_data_i    = 48'h000000000000;
      repeat (16) @(posedge mclk_i);
      reset_i <= 1'b0;
      t_reset();
      t_regs();
      t_chop(4'h0, 1'b1);
      t_chop(4'h3, 1'b1);
      t_chop(4'h6, 1'b1);
      t_chop(4'h3, 1'b0);
      wr(CFG_OFS, 16'h0000);
      wr(TH_UP_OFS, 16'h0001);
      wr(TH_LO_OFS, 16'h8000);
      for (int c = 0; c < 8; c++) t_detect(3'(c), c inside {1, 3, 5});
      for (int l = 0; l < 8; l++) t_window(3'(l));
      summarize();
   end

endmodule : tb_chop_detect_config
